/* File: verilog/tec_pkg.sv */
/*
 * Package for the 16-bit timer/event counter: register map, control
 * field positions, mode encodings and bus constants.
 * Assumes a single AHB-Lite master with 32-bit data and word access.
 */
package tec_pkg;

    // Byte addresses of the four registers (one aligned word each)
    localparam logic [7:0] TEC_ADDR_LOW  = 8'h00;
    localparam logic [7:0] TEC_ADDR_HIGH = 8'h04;
    localparam logic [7:0] TEC_ADDR_CTRL = 8'h08;
    localparam logic [7:0] TEC_ADDR_IRQ  = 8'h0C;

    // Control register fields
    localparam int TEC_MODE0_BIT = 6;
    localparam int TEC_MODE1_BIT = 7;
    localparam int TEC_RUN_BIT   = 4;
    localparam int TEC_EDGE_BIT  = 3;

    // Interrupt control register fields
    localparam int TEC_IRQ_EN_BIT   = 0;
    localparam int TEC_IRQ_FLAG_BIT = 1;

    localparam logic [7:0]  TEC_CTRL_RESET = 8'h00;
    localparam logic [15:0] TEC_FULL       = 16'hFFFF;
    localparam logic [15:0] TEC_ONE        = 16'h0001;
    localparam logic [1:0]  TEC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  TEC_HRESP_OKAY    = 2'h0;

    typedef enum logic [1:0] {
        TEC_MODE_OFF   = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PULSE = 2'b11
    } tec_mode_t;

    // Captured address phase of an AHB transfer
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } tec_aphase_t;

endpackage

/* File: verilog/tec_timer.sv */
/*
 * 16-bit up-counting timer/event counter with preload register, buffered
 * byte access and three modes: interval timer, event counter and pulse
 * width measurement. Registers are reached over AHB-Lite.
 * Assumes the timer pin is asynchronous to hclk; it is synchronised here.
 */
`timescale 1ns/1ns

module tec_timer
    import tec_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    input  wire logic        shared_timer_input_pin,
    input  wire logic        power_down,
    output logic             timer_irq,
    output logic             wake_request
);

    tec_aphase_t aph_reg;
    logic [15:0] preload_reg;
    logic [15:0] count_reg;
    logic [7:0]  low_buf_reg;
    logic [7:0]  rd_latch_reg;
    logic [7:0]  ctrl_reg;
    logic        irq_en_reg;
    logic        irq_flag_reg;
    logic [31:0] hrdata_reg;
    logic        pin_meta_reg;
    logic        pin_sync_reg;
    logic        pin_prev_reg;
    logic        pulse_act_reg;

    // Bus decode
    wire         take      = hsel & hready & (htrans == TEC_HTRANS_NONSEQ);
    wire         wr_low    = aph_reg.valid & aph_reg.write
                             & (aph_reg.addr == TEC_ADDR_LOW);
    wire         wr_high   = aph_reg.valid & aph_reg.write
                             & (aph_reg.addr == TEC_ADDR_HIGH);
    wire         wr_ctrl   = aph_reg.valid & aph_reg.write
                             & (aph_reg.addr == TEC_ADDR_CTRL);
    wire         wr_irq    = aph_reg.valid & aph_reg.write
                             & (aph_reg.addr == TEC_ADDR_IRQ);
    wire         rd_now    = take & ~hwrite;
    wire [7:0]   rd_addr   = haddr[7:0];
    wire         rd_high   = rd_now & (rd_addr == TEC_ADDR_HIGH);
    wire         rd_count  = rd_now & ((rd_addr == TEC_ADDR_HIGH)
                             | (rd_addr == TEC_ADDR_LOW));

    wire [1:0]   mode_bits = {ctrl_reg[TEC_MODE1_BIT],
                              ctrl_reg[TEC_MODE0_BIT]};
    wire         run       = ctrl_reg[TEC_RUN_BIT];
    wire         edge_sel  = ctrl_reg[TEC_EDGE_BIT];

    // Pin edges seen after the synchroniser
    wire         pin_rise  = pin_sync_reg & ~pin_prev_reg;
    wire         pin_fall  = ~pin_sync_reg & pin_prev_reg;
    // Edge bit low selects rising edges as active
    wire         act_edge  = edge_sel ? pin_fall : pin_rise;
    // Pulse mode has the opposite sense: edge bit low measures a low
    // pulse (falling start, rising end), high measures a high pulse
    wire         pls_start = edge_sel ? pin_rise : pin_fall;
    wire         ret_edge  = edge_sel ? pin_fall : pin_rise;
    // Pulse level follows the starting edge
    wire         act_level = edge_sel ? pin_sync_reg : ~pin_sync_reg;

    // Count qualification per mode
    logic tick;
    always_comb begin
        case (mode_bits)
            TEC_MODE_TIMER: tick = run;
            TEC_MODE_EVENT: tick = run & act_edge;
            TEC_MODE_PULSE: tick = run & pulse_act_reg & act_level;
            TEC_MODE_OFF:   tick = 1'b0;
            default:        tick = 1'b0;
        endcase
    end

    // Power-down gates the system-clock modes, never event counting
    wire         sys_ok    = ~power_down | (mode_bits == TEC_MODE_EVENT);
    // Inhibit during counter read and preload write
    wire         inhibit   = rd_count | wr_high;
    wire         inc       = tick & sys_ok & ~inhibit;
    wire         ovf       = inc & (count_reg == TEC_FULL);
    wire         pulse_end = run & (mode_bits == TEC_MODE_PULSE)
                             & pulse_act_reg & ret_edge;

    wire [15:0]  new_pre   = {hwdata[7:0], low_buf_reg};

    logic [15:0] preload_next;
    logic [15:0] count_next;
    always_comb begin
        preload_next = preload_reg;
        count_next   = count_reg;
        if (wr_high) begin
            preload_next = new_pre;
        end
        if (wr_high && !run) begin
            count_next = new_pre;
        end else if (ovf) begin
            // A fresh preload during run applies here
            count_next = preload_reg;
        end else if (inc) begin
            count_next = count_reg + TEC_ONE;
        end
    end

    logic [7:0] ctrl_next;
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = hwdata[7:0];
        end else if (pulse_end) begin
            ctrl_next[TEC_RUN_BIT] = 1'b0;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        case (rd_addr)
            TEC_ADDR_LOW:  rd_mux = {24'h000000, rd_latch_reg};
            TEC_ADDR_HIGH: rd_mux = {24'h000000, count_reg[15:8]};
            TEC_ADDR_CTRL: rd_mux = {24'h000000, ctrl_reg};
            TEC_ADDR_IRQ:  rd_mux = {30'h0, irq_flag_reg, irq_en_reg};
            default:       rd_mux = 32'h00000000;
        endcase
    end

    // Pin synchroniser; only the second and third stages feed logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= shared_timer_input_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Preload has no reset value on purpose
    always_ff @(posedge hclk) begin
        preload_reg <= preload_next;
        count_reg   <= count_next;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_reg     <= '0;
            low_buf_reg <= 8'h00;
            rd_latch_reg <= 8'h00;
            ctrl_reg    <= TEC_CTRL_RESET;
            hrdata_reg  <= 32'h00000000;
        end else begin
            aph_reg.valid <= take;
            aph_reg.write <= hwrite;
            aph_reg.addr  <= haddr[7:0];
            if (wr_low) begin
                low_buf_reg <= hwdata[7:0];
            end
            if (rd_high) begin
                rd_latch_reg <= count_reg[7:0];
            end
            ctrl_reg <= ctrl_next;
            if (rd_now) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // Pulse measurement arms on the starting edge once running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_act_reg <= 1'b0;
        end else if (!run || mode_bits != TEC_MODE_PULSE || pulse_end) begin
            pulse_act_reg <= 1'b0;
        end else if (pls_start) begin
            pulse_act_reg <= 1'b1;
        end
    end

    // Flag set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_reg   <= 1'b0;
            irq_flag_reg <= 1'b0;
        end else begin
            if (wr_irq) begin
                irq_en_reg <= hwdata[TEC_IRQ_EN_BIT];
            end
            if (ovf) begin
                irq_flag_reg <= 1'b1;
            end else if (wr_irq) begin
                irq_flag_reg <= hwdata[TEC_IRQ_FLAG_BIT];
            end
        end
    end

    assign timer_irq    = irq_flag_reg & irq_en_reg;
    // Overflow never asks for wake-up
    assign wake_request = 1'b0;
    assign hrdata       = hrdata_reg;
    assign hreadyout    = 1'b1;
    assign hresp        = TEC_HRESP_OKAY;

endmodule

/* File: dv/tec_timer_asserts.sv */
/* Port checker for tec_timer.
   Assumes hready is tied to hreadyout, so hsel and NONSEQ take a request. */
`timescale 1ns/1ns
module tec_chk
    import tec_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic [1:0]  hresp,
    input wire logic        timer_irq,
    input wire logic        wake_request
);
    wire logic ap = hsel && htrans == TEC_HTRANS_NONSEQ;
    wire logic rd = ap && !hwrite;
    logic      wdp;
    // High in every write data phase; only a register write may drop the irq
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) wdp <= 1'b0;
        else wdp <= ap && hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_READY: assert property (hreadyout) else $error("wait state");
    AST_OKAY: assert property (hresp == TEC_HRESP_OKAY) else $error("resp");
    AST_NO_WAKE: assert property (!wake_request)
        else $error("overflow woke device");
    AST_HOLD: assert property ($changed(hrdata) |-> $past(rd))
        else $error("hrdata moved");
    AST_UNMAP: assert property (rd && haddr[7:0] == 8'h10 |=> hrdata == '0)
        else $error("unmapped read");
    AST_IRQ_RD: assert property (rd && haddr[7:0] == TEC_ADDR_IRQ |=>
        (hrdata[0] && hrdata[1]) == $past(timer_irq)) else $error("irq");
    AST_IRQ_FALL: assert property ($fell(timer_irq) |-> $past(wdp))
        else $error("irq fell alone");
    AST_RST: assert property ($rose(hresetn) |-> hrdata == '0 && !timer_irq)
        else $error("reset state");
endmodule
bind tec_timer tec_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_irq(timer_irq),
    .wake_request(wake_request));

/* File: dv/tec_src.sv */
/* Timer pin source: from level lvl, toggles the pin n times, g+1 clocks
   apart. Holds its level between runs, as a real source does. */
`timescale 1ns/1ns
module tec_src (
    input  wire logic        hclk,
    input  wire logic        req,
    input  wire logic        lvl,
    input  wire logic [7:0]  n,
    input  wire logic [15:0] g,
    output logic             pin = 1'b0,
    output logic             busy
);
    logic [7:0]  left_reg = 8'h00;
    logic [15:0] wait_reg = 16'h0000;
    assign busy = left_reg != 8'h00;
    always @(posedge hclk) begin
        if (req) begin
            pin      <= lvl;
            left_reg <= n;
            wait_reg <= g;
        end else if (busy) begin
            wait_reg <= wait_reg - 16'h0001;
            if (wait_reg == 16'h0000) begin
                pin      <= !pin;
                left_reg <= left_reg - 8'h01;
                wait_reg <= g;
            end
        end
    end
endmodule

/* File: dv/tec_timer_tb.sv */
/* Bench for tec_timer: AHB-Lite master tasks, a pin source and an
   integer model of the count. Assumes a zero-wait-state slave. */
`timescale 1ns/1ns
module tec_timer_tb;
    import tec_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        pd = 1'b0, req = 1'b1, lvl = 1'b0, hrdy, irq, wake, pin, busy;
    logic [1:0]  htrans = 2'h0, hresp;
    logic [7:0]  tog = 8'h00;
    logic [15:0] gap = 16'h0003;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    int          mismatches = 0, samples_checked = 0, n, e;
    tec_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .shared_timer_input_pin(pin), .power_down(pd),
        .timer_irq(irq), .wake_request(wake));
    tec_src src (.hclk(hclk), .req(req), .lvl(lvl), .n(tog), .g(gap),
        .pin(pin), .busy(busy));
    initial forever #4 hclk = ~hclk;
    initial begin
        repeat (40000) @(posedge hclk);
        mismatches++;
        end_of_test;
    end
    task automatic chk(input string s, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= TEC_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input string s, input logic [7:0] a, input int x);
        wr(a, 1'b0, 8'h00);
        chk(s, q, x);
    endtask
    task automatic set16(input int v);
        wr(TEC_ADDR_LOW, 1'b1, v[7:0]);
        wr(TEC_ADDR_HIGH, 1'b1, v[15:8]);
    endtask
    task automatic rd16(input int v);
        rd("count high", TEC_ADDR_HIGH, v >> 8 & 255);
        rd("count low", TEC_ADDR_LOW, v & 255);
    endtask
    // Waits out the run plus the pin synchroniser before returning
    task automatic wave(input logic l, input int t, input int g);
        @(posedge hclk);
        lvl <= l;
        tog <= t[7:0];
        gap <= g[15:0];
        req <= 1'b1;
        @(posedge hclk);
        req <= 1'b0;
        @(posedge hclk);
        while (busy === 1'b1) @(posedge hclk);
        repeat (6) @(posedge hclk);
    endtask
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hA51C62F3));
        repeat (8) @(posedge hclk);
        req     <= 1'b0;
        hresetn <= 1'b1;
        rd("control", TEC_ADDR_CTRL, 0);
        rd("irq reg", TEC_ADDR_IRQ, 0);
        rd("unmapped", 8'h10, 0);
        $display("reset test done");
        n = $urandom & 16'hFFFF;
        set16(n);
        rd16(n);
        wr(TEC_ADDR_LOW, 1'b1, ~n[7:0]);
        rd16(n);
        wr(TEC_ADDR_HIGH, 1'b1, n[15:8]);
        n = n & 16'hFF00 | ~n & 255;
        wr(TEC_ADDR_CTRL, 1'b1, 8'h10);
        repeat (20) @(posedge hclk);
        rd16(n);
        $display("byte access test done");
        wr(TEC_ADDR_CTRL, 1'b1, 8'h00);
        set16(16'hFF00);
        wr(TEC_ADDR_IRQ, 1'b1, 8'h01);
        wr(TEC_ADDR_CTRL, 1'b1, 8'h80);
        wr(TEC_ADDR_CTRL, 1'b1, 8'h90);
        set16(16'h1200);
        for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge hclk);
        chk("overflow irq", irq, 1);
        wr(TEC_ADDR_CTRL, 1'b1, 8'h80);
        repeat (300) @(posedge hclk);
        rd("reload high", TEC_ADDR_HIGH, 8'h12);
        rd("irq reg", TEC_ADDR_IRQ, 3);
        wr(TEC_ADDR_IRQ, 1'b1, 8'h02);
        rd("irq reg", TEC_ADDR_IRQ, 2);
        chk("masked irq", irq, 0);
        wr(TEC_ADDR_IRQ, 1'b1, 8'h01);
        rd("irq reg", TEC_ADDR_IRQ, 1);
        $display("timer test done");
        for (e = 0; e < 2; e++) begin
            wave(1'b0, 0, 3);
            wr(TEC_ADDR_CTRL, 1'b1, 8'(8'h40 | e << 3));
            set16(0);
            wr(TEC_ADDR_CTRL, 1'b1, 8'(8'h50 | e << 3));
            pd <= 1'b1;
            n = $urandom_range(40, 1);
            wave(1'b0, n, 3);
            pd <= 1'b0;
            wr(TEC_ADDR_CTRL, 1'b1, 8'h40);
            rd16(e ? n / 2 : (n + 1) / 2);
        end
        $display("event test done");
        wave(1'b1, 0, 3);
        wr(TEC_ADDR_CTRL, 1'b1, 8'hC0);
        set16(0);
        wr(TEC_ADDR_CTRL, 1'b1, 8'hD0);
        for (e = 0; e < 2; e++) begin
            wave(1'b1, 2, 600);
            rd("pulse ctrl", TEC_ADDR_CTRL, 8'hC0);
            rd("pulse high", TEC_ADDR_HIGH, 2);
        end
        $display("pulse test done");
        end_of_test;
    end
endmodule
